// [irq_ctrl_pkg.sv]
package irq_ctrl_pkg;

    // ****************************************
    // register map (word aligned, APB)
    // ****************************************
    localparam logic [7:0] EDGE_SEL_OFFSET = 8'h00;
    localparam logic [7:0] CTRL_A_OFFSET = 8'h04;
    localparam logic [7:0] TOKEN_CTRL_OFFSET = 8'h08;
    localparam logic [7:0] CTRL_C_OFFSET = 8'h0C;
    localparam logic [7:0] TIMER_GROUP_OFFSET = 8'h10;
    localparam logic [7:0] CORE_STATUS_OFFSET = 8'h14;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int GLOBAL_EN_BIT = 0;
    localparam int FLAG_LSB = 4;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] EDGE_SEL_MASK = 8'h0F;
    localparam logic [7:0] CTRL_A_MASK = 8'h7F;
    localparam logic [7:0] CTRL_3EN_MASK = 8'h77;
    localparam logic [7:0] TIMER_GROUP_MASK = 8'hFF;

    // edge select codes
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // source index, lowest index is highest priority
    localparam int NUM_SRC = 9;
    localparam int SRC_PIN0 = 0;
    localparam int SRC_PIN1 = 1;
    localparam int SRC_USB = 2;
    localparam int SRC_SETUP = 3;
    localparam int SRC_EP0_IN = 4;
    localparam int SRC_EP0_OUT = 5;
    localparam int SRC_GROUP = 6;
    localparam int SRC_SERIAL = 7;
    localparam int SRC_LOW_V = 8;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic usb_engine;
        logic setup_token;
        logic ep0_in_token;
        logic ep0_out_token;
        logic serial_module;
        logic low_voltage;
        logic [3:0] timer_match;
    } src_event_s;

    typedef struct packed {
        logic take;
        logic [11:0] vector;
    } core_request_s;

endpackage

// [vectored_interrupt_controller.sv]
`timescale 1ns/1ps

// Summary of operation
// RULE_01: per pin two-bit edge code: off, rising, falling, both edges.
// RULE_02: trigger sets the request flag whatever the enable bits say.
// RULE_03: a flag vectors only while its own enable bit is one.
// RULE_04: global enable low blocks every interrupt.
// RULE_05: taking an interrupt pushes next address and loads the vector.
// RULE_06: return from interrupt pops the saved address.
// RULE_07: servicing any interrupt clears the global enable.
// RULE_08: requests arriving with global enable low still latch.
// RULE_09: software may set global enable in a routine to allow nesting.
// RULE_10: no request is taken while the stack is full.
// RULE_11: simultaneous enabled requests are taken in fixed priority order.
// RULE_12: any set flag raises the wake request for sleep or idle.
// RULE_13: control a: global enable bit 0, enables bits 1-3, flags bits 4-6.
// RULE_14: token control: enables bits 0-2, flags bits 4-6, bit 3 unused.
// RULE_15: control c: group, serial, low voltage enables 0-2, flags 4-6.
// RULE_16: timer group: match enables bits 0-3, match flags bits 4-7.
// RULE_17: implemented bits read/write and reset to zero, others read zero.
// RULE_18: servicing a dedicated source clears its flag with global enable.
// RULE_19: group flag sets whenever any grouped timer flag is set; code needs that flag's timer_enable bit as well, or a raw timer match.
// RULE_20: servicing the group clears only the group flag.
// RULE_21: usb engine flag sets on access to a non-zero endpoint.
// RULE_22: priority and vectors are fixed and exposed as parameters.
module vectored_interrupt_controller
    import irq_ctrl_pkg::*;
#(
    parameter logic [11:0] VECTOR_BASE = 12'h004,
    parameter logic [11:0] VECTOR_STEP = 12'h004
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // external interrupt pins
    input wire logic pin0_in,
    input wire logic pin1_in,
    // internal source events, one-cycle pulses
    input wire src_event_s event_in,
    // processor core sequencer
    input wire logic stack_full_in,
    input wire logic return_from_interrupt_in,
    input wire logic [11:0] next_pc_in,
    output core_request_s request_out,
    output logic [11:0] push_pc_out,
    output logic wake_out
);

    // ****************************************
    // state
    // ****************************************
    logic global_irq_enable;
    logic [3:0] edge_sel;
    logic [8:0] src_enable;
    logic [8:0] src_flag;
    logic [3:0] timer_enable;
    logic [3:0] timer_flag;
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [1:0] pin_prev;
    logic [1:0] pin_edge;
    logic [8:0] src_set;
    logic [8:0] pending;
    logic [3:0] sel_idx;
    logic take;
    logic in_service;
    logic bus_wr;
    logic [7:0] wdata;

    // note on the state above:
    // src_flag and src_enable share
    // one index, the source number;
    // index 0 is the highest priority.
    // timer flags and enables live
    // apart, as they never vector
    // alone; they feed the group.
    // in_service is a status bit only
    // and never gates arbitration, so
    // software may nest by setting
    // the global enable again.

    // priority pick to a binary index: lowest index wins
    function automatic logic [3:0] pick(input logic [8:0] req);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    // edge code decode, shared by both pins
    function automatic logic edge_hit(input logic [1:0] code, input logic now,
                                      input logic was);
        case (code)
            EDGE_RISE: edge_hit = now & ~was;
            EDGE_FALL: edge_hit = ~now & was;
            EDGE_BOTH: edge_hit = now ^ was;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    // edge detect hazards:
    // the previous-value flop resets low,
    // matching a pin that idles low;
    // a pin that idles high shows one
    // false rise after reset, which only
    // matters if code 01 or 11 is set
    // before the pin has settled.
    // latency is three clocks from the
    // pin to the flag, plus one to take.

    // ****************************************
    // pin synchronisers and edge detect
    // ****************************************
    // two flops before use; edge detect compares the second stage with pin_prev
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
            pin_prev <= 2'h0;
        end else begin
            pin_meta <= {pin1_in, pin0_in};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    generate
        for (genvar p = 0; p < 2; p++) begin : g_pin
            assign pin_edge[p] = edge_hit(edge_sel[2*p +: 2], pin_sync[p], pin_prev[p]); // RULE_01
        end
    endgenerate

    // ****************************************
    // source set terms
    // ****************************************
    // internal events arrive on this
    // clock already, so no synchroniser
    // is placed on them; a source on
    // another clock must pulse through
    // its own handshake first.
    // raw triggers, independent of the source enables; the group term also uses timer_enable
    assign src_set[SRC_PIN0] = pin_edge[0]; // RULE_02
    assign src_set[SRC_PIN1] = pin_edge[1];
    assign src_set[SRC_USB] = event_in.usb_engine; // RULE_21
    assign src_set[SRC_SETUP] = event_in.setup_token;
    assign src_set[SRC_EP0_IN] = event_in.ep0_in_token;
    assign src_set[SRC_EP0_OUT] = event_in.ep0_out_token;
    assign src_set[SRC_GROUP] = |(timer_flag & timer_enable) | |(event_in.timer_match); // RULE_19
    assign src_set[SRC_SERIAL] = event_in.serial_module;
    assign src_set[SRC_LOW_V] = event_in.low_voltage;

    // ****************************************
    // arbitration
    // ****************************************

    // the pick is combinational over
    // nine sources; a deeper tree would
    // need a pipeline stage and would
    // then need the clear to be delayed.
    assign pending = src_flag & src_enable; // RULE_03
    assign sel_idx = pick(pending); // RULE_11
    // stack full holds everything off until the core pops
    // nesting is gated by the global enable and stack full, not by in_service
    assign take = global_irq_enable & |pending & ~stack_full_in; // RULE_04 RULE_10

    // ****************************************
    // apb decode
    // ****************************************

    // limitation: only the low byte
    // of pwdata is used; upper bits
    // are dropped and read back zero.
    // pslverr is never raised, so an
    // unmapped word is silently ignored.
    // zero wait state slave; write lands in the access cycle
    assign bus_wr = psel_in & penable_in & pwrite_in;
    assign wdata = pwdata_in[7:0];
    assign pready_out = 1'b1;
    assign pslverr_out = 1'b0;

    // ****************************************
    // global enable
    // ****************************************
    // the global enable has one
    // hardware and one software writer:
    // the take clears it, software
    // sets it; take wins in one cycle
    // so a late write cannot slip an
    // unwanted nested entry through.
    // taking an interrupt beats a software write in the same cycle
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            global_irq_enable <= 1'b0;
        end else if (take) begin
            global_irq_enable <= 1'b0; // RULE_07
        end else if (bus_wr && paddr_in == CTRL_A_OFFSET) begin
            global_irq_enable <= wdata[GLOBAL_EN_BIT]; // RULE_09
        end
    end

    // ****************************************
    // enables and edge select
    // ****************************************
    // enables have no hardware writer;
    // only the bus changes them.
    // unused bits of each word are
    // dropped here and read back zero.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            edge_sel <= 4'h0; // RULE_17
            src_enable <= 9'h000;
            timer_enable <= 4'h0;
        end else if (bus_wr) begin
            case (paddr_in)
                EDGE_SEL_OFFSET: edge_sel <= wdata[3:0];
                CTRL_A_OFFSET: src_enable[2:0] <= wdata[3:1]; // RULE_13
                TOKEN_CTRL_OFFSET: src_enable[5:3] <= wdata[2:0]; // RULE_14
                CTRL_C_OFFSET: src_enable[8:6] <= wdata[2:0]; // RULE_15
                TIMER_GROUP_OFFSET: timer_enable <= wdata[3:0]; // RULE_16
                default: ;
            endcase
        end
    end

    // ****************************************
    // request flags
    // ****************************************

    // clear order per flag bit:
    //  1. hardware set (wins always)
    //  2. service clear of the chosen
    //     source, same edge as take
    //  3. software write of the bit
    // a write of one to a flag sets it,
    // which software may use to raise
    // a request by hand.
    // per bit: set wins over write-clear and service-clear
    generate
        for (genvar s = 0; s < NUM_SRC; s++) begin : g_flag
            logic wr_hit;
            logic wr_val;
            always_comb begin
                wr_hit = 1'b0;
                wr_val = 1'b0;
                if (bus_wr) begin
                    if (s < 3 && paddr_in == CTRL_A_OFFSET) begin
                        wr_hit = 1'b1;
                        wr_val = wdata[FLAG_LSB + (s % 3)];
                    end else if (s >= 3 && s < 6 && paddr_in == TOKEN_CTRL_OFFSET) begin
                        wr_hit = 1'b1;
                        wr_val = wdata[FLAG_LSB + (s % 3)];
                    end else if (s >= 6 && paddr_in == CTRL_C_OFFSET) begin
                        wr_hit = 1'b1;
                        wr_val = wdata[FLAG_LSB + (s % 3)];
                    end
                end
            end
            always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    src_flag[s] <= 1'b0;
                end else if (src_set[s]) begin
                    src_flag[s] <= 1'b1; // RULE_08
                end else if (take && sel_idx == 4'(s)) begin
                    src_flag[s] <= 1'b0; // RULE_18 RULE_20
                end else if (wr_hit) begin
                    src_flag[s] <= wr_val;
                end
            end
        end
    endgenerate

    // a timer flag left set with its
    // enable on keeps re-setting the
    // group flag after service.
    // timer flags are never cleared by service, only by software
    generate
        for (genvar t = 0; t < 4; t++) begin : g_tflag
            always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    timer_flag[t] <= 1'b0;
                end else if (event_in.timer_match[t]) begin
                    timer_flag[t] <= 1'b1; // RULE_02
                end else if (bus_wr && paddr_in == TIMER_GROUP_OFFSET) begin
                    timer_flag[t] <= wdata[FLAG_LSB + t]; // RULE_20
                end
            end
        end
    endgenerate

    // ****************************************
    // core request
    // ****************************************
    // in_service spans from take to return, status only
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            in_service <= 1'b0;
        end else if (take) begin
            in_service <= 1'b1;
        end else if (return_from_interrupt_in) begin
            in_service <= 1'b0; // RULE_06
        end
    end


    // the vector formula keeps one
    // slot per source; base and step
    // come in as parameters so the
    // table can move with the program
    // memory map without code change.
    // push_pc captures next_pc in the
    // taking cycle, before the core
    // has started the jump.
    // registered request pulse with vector and return address
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            request_out <= '0;
            push_pc_out <= 12'h000;
        end else begin
            request_out.take <= take; // RULE_05
            if (take) begin
                request_out.vector <= 12'(VECTOR_BASE + VECTOR_STEP * 12'(sel_idx)); // RULE_22
                push_pc_out <= next_pc_in;
            end
        end
    end


    // wake is a level, not a pulse:
    // it stays high while any flag is
    // set, so software must clear the
    // flag before sleeping if no wake
    // is wanted.
    // wake request from any set flag
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wake_out <= 1'b0;
        end else begin
            wake_out <= |src_flag | |timer_flag; // RULE_12
        end
    end

    // ****************************************
    // read data
    // ****************************************

    // reads are captured in the setup
    // cycle; a write in the same access
    // is not seen by that read.
    // the status word is read only.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (psel_in && !penable_in && !pwrite_in) begin
            case (paddr_in)
                EDGE_SEL_OFFSET: prdata_out <= {28'h0, edge_sel};
                CTRL_A_OFFSET: prdata_out <= {25'h0, src_flag[2:0], src_enable[2:0],
                                              global_irq_enable};
                TOKEN_CTRL_OFFSET: prdata_out <= {25'h0, src_flag[5:3], 1'b0, src_enable[5:3]};
                CTRL_C_OFFSET: prdata_out <= {25'h0, src_flag[8:6], 1'b0, src_enable[8:6]};
                TIMER_GROUP_OFFSET: prdata_out <= {24'h0, timer_flag, timer_enable};
                CORE_STATUS_OFFSET: prdata_out <= {26'h0, in_service, sel_idx, take};
                default: prdata_out <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// [irq_ctrl_properties.sv]
`timescale 1ns/1ps
// ****************************************
// port checks for the interrupt controller
// ****************************************
module irq_ctrl_properties
    import irq_ctrl_pkg::*;
#(
    parameter logic [11:0] VECTOR_BASE = 12'h004,
    parameter logic [11:0] VECTOR_STEP = 12'h004
) (
    // clock, reset and bus answer
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // sources and core side
    input wire src_event_s event_in,
    input wire logic stack_full_in,
    input wire logic return_from_interrupt_in,
    input wire logic [11:0] next_pc_in,
    input wire core_request_s request_out,
    input wire logic [11:0] push_pc_out,
    input wire logic wake_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    // zero wait, never an error, so masters never stall
    bus_ready_a: assert property (pready_out && !pslverr_out)
        else $error("bus answer not ready or flagged error");
    take_pulse_a: assert property (request_out.take |=> !request_out.take)
        else $error("take held longer than one cycle");
    stack_block_a: assert property (stack_full_in [*3] |=> !request_out.take)
        else $error("request taken while stack full");
    // vector and pushed address must not drift between takes
    vector_hold_a: assert property (!request_out.take |->
        $stable(request_out.vector) && $stable(push_pc_out))
        else $error("vector or pushed address moved without take");
    vector_map_a: assert property (request_out.take |->
        request_out.vector >= VECTOR_BASE
        && (request_out.vector - VECTOR_BASE) % VECTOR_STEP == 0
        && (request_out.vector - VECTOR_BASE) / VECTOR_STEP < NUM_SRC)
        else $error("vector outside the source table");
    push_pc_a: assert property (request_out.take |-> push_pc_out == $past(next_pc_in))
        else $error("pushed address is not the next address");
    // global enable cleared at the take, so software needs a later write
    service_gate_a: assert property (request_out.take |=> (!request_out.take) [*2])
        else $error("second take too soon after a take");
    // timer flags are never auto cleared, so wake must follow
    wake_timer_a: assert property ((|event_in.timer_match) |-> ##[1:3] wake_out)
        else $error("timer match did not raise wake");
endmodule

bind vectored_interrupt_controller irq_ctrl_properties #(
    .VECTOR_BASE(VECTOR_BASE), .VECTOR_STEP(VECTOR_STEP)) i_irq_ctrl_properties (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .event_in(event_in), .stack_full_in(stack_full_in),
    .return_from_interrupt_in(return_from_interrupt_in), .next_pc_in(next_pc_in),
    .request_out(request_out), .push_pc_out(push_pc_out), .wake_out(wake_out));

// [core_sequencer_model.sv]
`timescale 1ns/1ps
// ****************************************
// processor sequencer and return stack
// ****************************************
module core_sequencer_model
    import irq_ctrl_pkg::*;
#(
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // controller side
    input wire core_request_s request_in,
    input wire logic [11:0] push_pc_in,
    output logic [11:0] next_pc_out,
    output logic return_out,
    output logic stack_full_out,
    // bench controls
    input wire logic [11:0] start_pc_in,
    input wire logic hold_full_in,
    input wire logic [3:0] ret_wait_in
);
    logic [11:0] stack[$];
    int depth;
    int wait_cnt;

    // bench may pin the stack full to test blocking
    assign stack_full_out = hold_full_in || (depth >= DEPTH);

    // jump on take, pop on return after a variable routine length
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stack.delete();
            depth <= 0;
            next_pc_out <= start_pc_in;
            return_out <= 1'h0;
            wait_cnt <= 0;
        end else begin
            return_out <= 1'h0;
            if (request_in.take) begin
                stack.push_back(push_pc_in);
                depth <= depth + 1;
                next_pc_out <= request_in.vector;
                wait_cnt <= ret_wait_in + 1;
            end else if (wait_cnt == 1) begin
                return_out <= 1'h1;
                next_pc_out <= stack.pop_back();
                depth <= depth - 1;
                // nested levels each get their own return
                wait_cnt <= (depth > 1) ? ret_wait_in + 1 : 0;
            end else if (wait_cnt > 1) begin
                wait_cnt <= wait_cnt - 1;
            end
        end
    end
endmodule

// [vectored_interrupt_controller_tb.sv]
`timescale 1ns/1ps
// ****************************************
// bench for the interrupt controller
// ****************************************
module vectored_interrupt_controller_tb
    import irq_ctrl_pkg::*;
;
    localparam logic [11:0] VB = 12'h010;
    localparam logic [11:0] VS = 12'h008;
    logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic pin0 = 1'h0, pin1 = 1'h0, hold_full = 1'h0;
    logic pready, pslverr, stack_full, ret, wake;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [11:0] next_pc, push_pc, start_pc = 12'h000;
    logic [3:0] ret_wait = 4'h1;
    src_event_s ev = '0;
    core_request_s req;
    int fails = 0, compares = 0, takes = 0, seed = 32'hBD77, idx, t0;
    int mdl[5];
    logic [7:0] offs[6] = '{EDGE_SEL_OFFSET, CTRL_A_OFFSET, TOKEN_CTRL_OFFSET,
        CTRL_C_OFFSET, TIMER_GROUP_OFFSET, 8'h18};
    logic [7:0] masks[6] = '{EDGE_SEL_MASK, 8'h7E, CTRL_3EN_MASK, CTRL_3EN_MASK,
        TIMER_GROUP_MASK, 8'h00};

    vectored_interrupt_controller #(.VECTOR_BASE(VB), .VECTOR_STEP(VS))
        i_vectored_interrupt_controller (
        .ref_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .pin0_in(pin0), .pin1_in(pin1),
        .event_in(ev), .stack_full_in(stack_full), .return_from_interrupt_in(ret),
        .next_pc_in(next_pc), .request_out(req), .push_pc_out(push_pc), .wake_out(wake));
    core_sequencer_model i_core_sequencer_model (
        .clk_in(clk), .rst_b_in(rst_b), .request_in(req), .push_pc_in(push_pc),
        .next_pc_out(next_pc), .return_out(ret), .stack_full_out(stack_full),
        .start_pc_in(start_pc), .hold_full_in(hold_full), .ret_wait_in(ret_wait));

    always #4 clk = ~clk;
    always @(posedge clk) if (req.take === 1'h1) takes <= takes + 1;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) hang();
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // wait on the take count, not a level, so a fast repeat is not missed
    task automatic wait_take(input int target);
        int n = 0;
        while (takes < target && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n >= 300) hang();
    endtask
    task hang;
        fails++;
        report_and_stop();
    endtask
    task report_and_stop;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        start_pc = 12'($random(seed));
        ret_wait = 4'($random(seed)) & 4'h7;
        repeat (12) @(posedge clk);
        rst_b <= 1'h1;
        // reset values, masks, unmapped word; global enable kept low
        for (int i = 0; i < 6; i++) begin
            apb(1'h0, offs[i], 32'h0);
            chk("reset value", 32'h0, rd);
            apb(1'h1, offs[i], (i == 1) ? 32'hFFFFFFFE : 32'hFFFFFFFF);
            apb(1'h0, offs[i], 32'h0);
            chk("write mask", {24'h0, masks[i]}, rd);
            apb(1'h1, offs[i], 32'h0);
        end
        apb(1'h1, CTRL_C_OFFSET, 32'h0);
        chk("no take", 0, takes);
        $display("test registers done");
        // each edge code against a rise then a fall on both pins
        for (int c = 0; c < 4; c++) for (int e = 0; e < 2; e++) begin
            apb(1'h1, EDGE_SEL_OFFSET, 32'({c[1:0], c[1:0]}));
            @(posedge clk);
            pin0 <= ~pin0;
            pin1 <= ~pin1;
            repeat (6) @(posedge clk);
            apb(1'h0, CTRL_A_OFFSET, 32'h0);
            chk("pin flags", {26'h0, {2{c[e]}}, 4'h0}, rd);
            apb(1'h1, CTRL_A_OFFSET, 32'h0);
        end
        $display("test edges done");
        // all sources fire with enables on and global enable off
        apb(1'h1, EDGE_SEL_OFFSET, 32'h0F);
        apb(1'h1, CTRL_A_OFFSET, 32'h0E);
        apb(1'h1, TOKEN_CTRL_OFFSET, 32'h07);
        apb(1'h1, CTRL_C_OFFSET, 32'h07);
        @(posedge clk);
        ev <= src_event_s'(10'h3F1);
        pin0 <= 1'h1;
        pin1 <= 1'h1;
        @(posedge clk);
        ev <= '0;
        repeat (8) @(posedge clk);
        mdl = '{32'h0F, 32'h7E, 32'h77, 32'h77, 32'h10};
        for (int i = 0; i < 5; i++) begin
            apb(1'h0, offs[i], 32'h0);
            chk("latched flags", mdl[i], rd);
        end
        chk("held off", 0, takes);
        chk("wake", 1, wake);
        $display("test latch done");
        // global enable on: nine takes in priority order, re-armed inside
        t0 = takes;
        apb(1'h1, CTRL_A_OFFSET, mdl[1] | 1);
        for (int k = 0; k < 9; k++) begin
            wait_take(t0 + k + 1);
            for (int j = 8; j >= 0; j--)
                if (mdl[1 + j / 3][4 + j % 3] && mdl[1 + j / 3][(j < 3) ? 1 + j % 3 : j % 3])
                    idx = j;
            chk("vector", {20'h0, VB + VS * 12'(idx)}, req.vector);
            mdl[1 + idx / 3][4 + idx % 3] = 1'h0;
            apb(1'h1, CTRL_A_OFFSET, mdl[1] | 1);
        end
        repeat (60) @(posedge clk);
        mdl[1] = mdl[1] | 1;
        for (int i = 1; i < 5; i++) begin
            apb(1'h0, offs[i], 32'h0);
            chk("after service", mdl[i], rd);
        end
        chk("return pc", {20'h0, start_pc}, {20'h0, next_pc});
        $display("test priority done");
        // a pending request waits out a full stack
        @(posedge clk);
        hold_full <= 1'h1;
        ev.low_voltage <= 1'h1;
        @(posedge clk);
        ev.low_voltage <= 1'h0;
        repeat (20) @(posedge clk);
        chk("blocked", t0 + 9, takes);
        hold_full <= 1'h0;
        wait_take(t0 + 10);
        chk("vector", {20'h0, VB + VS * 12'h8}, req.vector);
        apb(1'h0, CTRL_A_OFFSET, 32'h0);
        chk("global cleared", 32'h0E, rd);
        $display("test stack done");
        report_and_stop();
    end
endmodule
